// *** src/ifs_clkdiv.sv ***
`timescale 1ns/1ps
module ifs_clkdiv
  import ifs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Oscillator option, static after reset
  input wire logic [1:0] osc_sel,
  // One-cycle instruction tick
  output logic cyc_tick
);
  typedef struct packed {
    logic [3:0] cnt;
  } ifs_div_t;

  ifs_div_t s_r;
  ifs_div_t s_nxt;
  logic [3:0] div;

  always_comb begin
    div = (osc_sel == OSC_XTAL) ? DIV_XTAL : DIV_RC;
    s_nxt = s_r;
    if (s_r.cnt == 4'h0) begin
      s_nxt.cnt = div - 4'h1;
    end else begin
      s_nxt.cnt = s_r.cnt - 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cyc_tick = (s_r.cnt == 4'h0);

  property p_div_xtal;
    @(posedge clk_sys) disable iff (!nrst)
    (cyc_tick && osc_sel == OSC_XTAL && $past(cyc_tick) == 1'b0) |=> !cyc_tick [*7] ##1 cyc_tick;
  endproperty
  a_div_xtal: assert property (p_div_xtal) else $error("crystal divide is not eight");

  property p_div_rc;
    @(posedge clk_sys) disable iff (!nrst)
    (cyc_tick && osc_sel != OSC_XTAL && $stable(osc_sel)) |=> !cyc_tick [*3] ##1 cyc_tick;
  endproperty
  a_div_rc: assert property (p_div_rc) else $error("rc divide is not four");
endmodule

// *** src/ifs_core.sv ***
`timescale 1ns/1ps
module ifs_core
  import ifs_pkg::*;
#(
  parameter int ROM_DEPTH = IFS_ROM_DEPTH,
  parameter int RAM_DEPTH = IFS_RAM_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Oscillator mask option
  input wire logic [1:0] osc_sel,
  // Program image load port
  input wire logic rom_wr_en,
  input wire logic [8:0] rom_wr_addr,
  input wire logic [7:0] rom_wr_data,
  // Serial pins
  input wire logic si_pin,
  input wire logic so_pin_i,
  output ifs_serial_out_t ser_out,
  // Status
  output logic [8:0] pc_out,
  output logic [7:0] lookup_out,
  output logic [3:0] working_out,
  output logic [3:0] shift_count_out,
  output logic [3:0] func_sel_out,
  output logic [8:0] first_return_slot,
  output logic [8:0] second_return_slot,
  output logic cyc_tick_out,
  output ifs_test_t test_mode
);
  ifs_state_t s_r;
  ifs_state_t s_nxt;

  logic [7:0] rom_mem [ROM_DEPTH];
  logic [3:0] ram_mem [RAM_DEPTH];

  logic cyc_tick;
  logic test_any;
  logic run;
  logic [8:0] rd_addr;
  logic [7:0] rom_dat;
  logic [8:0] pcn;
  logic [3:0] m_nib;
  logic [4:0] ram_idx;
  logic ram_we;
  logic [3:0] ram_wd;
  logic [4:0] sum;
  logic swapped;
  logic shift_mode;

  function automatic logic is_two_byte(input logic [7:0] b);
    is_two_byte = (b == OPC_PREFIX) || (b[7:4] == OPC_HI_LONG);
  endfunction

  ifs_clkdiv u_div (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .osc_sel(osc_sel),
    .cyc_tick(cyc_tick)
  );

  // Pointed RAM nibble is read through the pointer register
  assign ram_idx = {s_r.br[0], s_r.bd};
  assign m_nib = ram_mem[ram_idx];
  // Eight pages of 64 words under one 9-bit address
  assign rd_addr = (s_r.phase == PH_INDIRECT) ? s_r.ind_addr : s_r.pc;
  assign rom_dat = rom_mem[rd_addr];
  assign pcn = s_r.pc + 9'h001;
  // Test mode only when the pin is held high against our own low drive
  assign test_any = s_r.so_s && !s_r.so;
  assign run = cyc_tick && !test_any;
  assign shift_mode = !s_r.en[EN_COUNT_BIT];

  always_comb begin
    s_nxt = s_r;
    ram_we = 1'b0;
    ram_wd = NIB_RST;
    sum = 5'h00;
    swapped = 1'b0;
    s_nxt.si_m = si_pin;
    s_nxt.si_s = s_r.si_m;
    s_nxt.si_prev = s_r.si_s;
    s_nxt.so_m = so_pin_i;
    s_nxt.so_s = s_r.so_m;
    if (run) begin
      case (s_r.phase)
        PH_FETCH: begin
          s_nxt.pc = pcn;
          if (s_r.skip) begin
            // Skipped byte costs one cycle and has no effect
            if (is_two_byte(rom_dat)) begin
              s_nxt.phase = PH_OPERAND;
              s_nxt.op = rom_dat;
            end else begin
              s_nxt.skip = 1'b0;
            end
          end else if (rom_dat == OPC_INDIRECT_JUMP) begin
            // Address top bit from pc+1 so last-word placement uses the next page
            s_nxt.ind_addr = {pcn[8], s_r.a, m_nib};
            s_nxt.op = rom_dat;
            s_nxt.phase = PH_INDIRECT;
          end else if (rom_dat == OPC_TABLE_LOAD) begin
            s_nxt.sb = s_r.sa;
            s_nxt.sa = pcn;
            s_nxt.pc = {pcn[8], s_r.a, m_nib};
            s_nxt.ind_addr = {pcn[8], s_r.a, m_nib};
            s_nxt.op = rom_dat;
            s_nxt.phase = PH_INDIRECT;
          end else if (rom_dat[7]) begin
            if (pcn[8:7] == 2'b01) begin
              // Pages 2 and 3 jump across their pair
              s_nxt.pc = {pcn[8:7], rom_dat[6:0]};
            end else if (rom_dat[6]) begin
              s_nxt.pc = {pcn[8:6], rom_dat[5:0]};
            end else begin
              s_nxt.sb = s_r.sa;
              s_nxt.sa = pcn;
              s_nxt.pc = {PAGE_TWO_TOP, rom_dat[5:0]};
            end
          end else if (is_two_byte(rom_dat)) begin
            s_nxt.op = rom_dat;
            s_nxt.phase = PH_OPERAND;
          end else if (rom_dat == OPC_ZERO_WORKING) begin
            s_nxt.a = NIB_RST;
          end else if (rom_dat == OPC_SWAP_SHIFT) begin
            s_nxt.a = s_r.shift_count_reg;
            s_nxt.shift_count_reg = s_r.a;
            s_nxt.sk_l = s_r.c;
            swapped = 1'b1;
          end else if (rom_dat == OPC_SET_CARRY) begin
            s_nxt.c = 1'b1;
          end else if (rom_dat == OPC_RESET_CARRY) begin
            s_nxt.c = 1'b0;
          end else if (rom_dat == OPC_SKIP_CARRY) begin
            s_nxt.skip = s_r.c;
          end else if (rom_dat == OPC_RETURN || rom_dat == OPC_RETURN_SKIP) begin
            s_nxt.pc = s_r.sa;
            s_nxt.sa = s_r.sb;
            s_nxt.skip = rom_dat[0];
          end else if (rom_dat == OPC_COPY_DIGIT) begin
            s_nxt.bd = s_r.a;
          end else if (rom_dat[7:4] == OPC_HI_ADD_IMM) begin
            sum = {1'b0, s_r.a} + {1'b0, rom_dat[3:0]};
            s_nxt.a = sum[3:0];
            s_nxt.skip = sum[4];
          end else if (rom_dat[7:4] == OPC_HI_STORE_IMM) begin
            ram_we = 1'b1;
            ram_wd = rom_dat[3:0];
            s_nxt.bd = s_r.bd + 4'h1;
          end
        end
        PH_OPERAND: begin
          s_nxt.pc = pcn;
          s_nxt.phase = PH_FETCH;
          if (s_r.skip) begin
            s_nxt.skip = 1'b0;
          end else if (s_r.op == OPC_PREFIX) begin
            if (rom_dat[7:4] == OPC_HI_LONG) begin
              s_nxt.en = rom_dat[3:0];
            end
          end else if (s_r.op[3:1] == OPC_LONG_JUMP) begin
            s_nxt.pc = {s_r.op[0], rom_dat};
          end else if (s_r.op[3:1] == OPC_LONG_CALL) begin
            s_nxt.sb = s_r.sa;
            s_nxt.sa = pcn;
            s_nxt.pc = {s_r.op[0], rom_dat};
          end
        end
        PH_INDIRECT: begin
          s_nxt.phase = PH_FETCH;
          if (s_r.op == OPC_INDIRECT_JUMP) begin
            s_nxt.pc = {s_r.ind_addr[8], rom_dat};
          end else begin
            // Pop leaves the old first slot value in the second slot
            s_nxt.q = rom_dat;
            s_nxt.pc = s_r.sa;
            s_nxt.sa = s_r.sb;
          end
        end
        default: begin
          s_nxt.phase = PH_FETCH;
        end
      endcase
    end
    // Shift one bit per instruction cycle; the swap overrides that cycle
    if (shift_mode) begin
      if (run && !swapped) begin
        s_nxt.shift_count_reg = {s_r.shift_count_reg[2:0], s_r.si_s};
      end
    end else if (!swapped && s_r.si_prev && !s_r.si_s) begin
      s_nxt.shift_count_reg = s_r.shift_count_reg + 4'h1;
    end
    s_nxt.so = shift_mode ? s_r.shift_count_reg[3] : s_r.en[EN_SO_BIT];
    // Shift mode gates one clock per cycle; counter mode shows the latch
    s_nxt.sk = shift_mode ? (s_r.sk_l && cyc_tick) : s_r.sk_l;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rom_wr_en) begin
      rom_mem[rom_wr_addr] <= rom_wr_data;
    end
    if (ram_we) begin
      ram_mem[ram_idx] <= ram_wd;
    end
  end

  assign ser_out.so_o = s_r.so;
  assign ser_out.so_oe_n = 1'b0;
  assign ser_out.sk_o = s_r.sk;
  assign pc_out = s_r.pc;
  assign lookup_out = s_r.q;
  assign working_out = s_r.a;
  assign shift_count_out = s_r.shift_count_reg;
  assign func_sel_out = s_r.en;
  assign first_return_slot = s_r.sa;
  assign second_return_slot = s_r.sb;
  assign cyc_tick_out = cyc_tick;
  assign test_mode.ram_logic = test_any && s_r.si_s;
  assign test_mode.rom = test_any && !s_r.si_s;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  property p_swap;
    (run && s_r.phase == PH_FETCH && !s_r.skip && rom_dat == OPC_SWAP_SHIFT)
      |=> (s_r.a == $past(s_r.shift_count_reg)) && (s_r.shift_count_reg == $past(s_r.a));
  endproperty
  a_swap: assert property (p_swap) else $error("swap did not exchange nibbles");

  property p_sk_latch;
    (run && s_r.phase == PH_FETCH && !s_r.skip && rom_dat == OPC_SWAP_SHIFT)
      |=> s_r.sk_l == $past(s_r.c) ##1 s_r.sk == (shift_mode ? (s_r.sk_l && $past(cyc_tick)) : s_r.sk_l);
  endproperty
  a_sk_latch: assert property (p_sk_latch) else $error("serial clock not taken from carry");

  property p_shift;
    (run && shift_mode && !swapped) |=> s_r.shift_count_reg == {$past(s_r.shift_count_reg[2:0]), $past(s_r.si_s)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift register did not shift");

  property p_jid_two;
    (run && s_r.phase == PH_FETCH && !s_r.skip && rom_dat == OPC_INDIRECT_JUMP)
      |=> s_r.phase == PH_INDIRECT && s_r.pc == $past(s_r.pc) + 9'h001;
  endproperty
  a_jid_two: assert property (p_jid_two) else $error("indirect jump not two cycles");

  property p_jid_load;
    (run && s_r.phase == PH_INDIRECT && s_r.op == OPC_INDIRECT_JUMP)
      |=> s_r.pc == {$past(s_r.ind_addr[8]), $past(rom_dat)} && s_r.phase == PH_FETCH;
  endproperty
  a_jid_load: assert property (p_jid_load) else $error("indirect jump target wrong");

  property p_table_load_op_pop;
    (run && s_r.phase == PH_INDIRECT && s_r.op == OPC_TABLE_LOAD)
      |=> s_r.q == $past(rom_dat) && s_r.pc == $past(s_r.sa) && s_r.sa == $past(s_r.sb)
          && s_r.sb == $past(s_r.sb);
  endproperty
  a_table_load_op_pop: assert property (p_table_load_op_pop) else $error("table load latch or pop wrong");

  property p_table_load_op_push;
    (run && s_r.phase == PH_FETCH && !s_r.skip && rom_dat == OPC_TABLE_LOAD)
      |=> s_r.sb == $past(s_r.sa) && s_r.pc[7:0] == {$past(s_r.a), $past(m_nib)};
  endproperty
  a_table_load_op_push: assert property (p_table_load_op_push) else $error("table load push wrong");

  property p_skip_one;
    (run && s_r.phase == PH_FETCH && s_r.skip && !is_two_byte(rom_dat))
      |=> s_r.phase == PH_FETCH && !s_r.skip && $stable(s_r.a) && $stable(s_r.sa) && $stable(s_r.q);
  endproperty
  a_skip_one: assert property (p_skip_one) else $error("skipped byte changed state");

  property p_page_cross;
    (run && s_r.phase == PH_FETCH && !s_r.skip && rom_dat == OPC_ZERO_WORKING)
      |=> s_r.pc == $past(s_r.pc) + 9'h001;
  endproperty
  a_page_cross: assert property (p_page_cross) else $error("counter did not advance by one");

  property p_test;
    (s_r.so_s && !s_r.so) |-> test_mode.ram_logic == s_r.si_s && test_mode.rom == !s_r.si_s;
  endproperty
  a_test: assert property (p_test) else $error("test mode select wrong");
endmodule

// *** src/ifs_pkg.sv ***
// Summary of operation
// - Swap-shift op exchanges the whole working nibble with the shift/count register.
// - Shift/count register shifts serially or counts, chosen by the function select latch.
// - Swap-shift op also latches carry to drive the serial clock output.
// - Indirect jump loads counter bits 7..0 from ROM(top bit, nibble, RAM); top bit kept.
// - Indirect jump takes two instruction cycles.
// - Table load fills the 8-bit lookup latch from ROM(top bit, nibble, RAM nibble).
// - Table load pushes counter+1, points at nibble/RAM, fetches into latch, then pops.
// - After table load the second slot holds the old first slot contents.
// - Table load takes two instruction cycles.
// - Skipped instructions change nothing but spend one cycle per byte.
// - Indirect jump and table load take two cycles executed, one cycle skipped.
// - Program memory is eight pages of sixty-four words.
// - Program counter is a 9-bit binary counter crossing page boundaries.
// - Page jump, page-two call, indirect ops in a page's last word act as next page.
// - Indirect ops in last word of page 3 or 7 read the next four-page group.
// - Serial output forced high enters factory test; serial input picks RAM/logic or ROM.
// - Instruction clock is input clock divided by eight (crystal) or four (RC, Schmitt).
// - The pointed RAM nibble is the RAM word selected by the RAM pointer.
// - Both return slots are nine bits wide.
package ifs_pkg;
  localparam int IFS_PC_W = 9;
  localparam int IFS_PAGE_W = 6;
  localparam int IFS_NPAGES = 8;
  localparam int IFS_ROM_DEPTH = IFS_NPAGES << IFS_PAGE_W;
  localparam int IFS_RAM_DEPTH = 32;

  localparam logic [7:0] OPC_ZERO_WORKING = 8'h00;
  localparam logic [7:0] OPC_SWAP_SHIFT = 8'h4F;
  localparam logic [7:0] OPC_INDIRECT_JUMP = 8'hFF;
  localparam logic [7:0] OPC_TABLE_LOAD = 8'hBF;
  localparam logic [7:0] OPC_RETURN = 8'h48;
  localparam logic [7:0] OPC_RETURN_SKIP = 8'h49;
  localparam logic [7:0] OPC_SKIP_CARRY = 8'h20;
  localparam logic [7:0] OPC_SET_CARRY = 8'h22;
  localparam logic [7:0] OPC_RESET_CARRY = 8'h32;
  localparam logic [7:0] OPC_COPY_DIGIT = 8'h50;
  localparam logic [7:0] OPC_PREFIX = 8'h33;
  localparam logic [3:0] OPC_HI_ADD_IMM = 4'h5;
  localparam logic [3:0] OPC_HI_LONG = 4'h6;
  localparam logic [3:0] OPC_HI_STORE_IMM = 4'h7;
  localparam logic [2:0] OPC_LONG_JUMP = 3'h0;
  localparam logic [2:0] OPC_LONG_CALL = 3'h4;
  localparam logic [2:0] PAGE_TWO_TOP = 3'h2;

  localparam int EN_COUNT_BIT = 0;
  localparam int EN_SO_BIT = 3;

  localparam logic [1:0] OSC_XTAL = 2'h0;
  localparam logic [1:0] OSC_RC = 2'h1;
  localparam logic [1:0] OSC_SCHMITT = 2'h2;
  localparam logic [3:0] DIV_XTAL = 4'h8;
  localparam logic [3:0] DIV_RC = 4'h4;

  localparam logic [8:0] PC_RST = 9'h000;
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [1:0] {
    PH_FETCH = 2'b00,
    PH_OPERAND = 2'b01,
    PH_INDIRECT = 2'b10
  } ifs_phase_t;

  typedef struct packed {
    logic so_o;
    logic so_oe_n;
    logic sk_o;
  } ifs_serial_out_t;

  typedef struct packed {
    logic ram_logic;
    logic rom;
  } ifs_test_t;

  typedef struct packed {
    logic [8:0] pc;
    logic [3:0] a;
    logic c;
    logic [8:0] sa;
    logic [8:0] sb;
    logic [3:0] shift_count_reg;
    logic [3:0] en;
    logic [7:0] q;
    logic [3:0] bd;
    logic [1:0] br;
    logic skip;
    ifs_phase_t phase;
    logic [7:0] op;
    logic [8:0] ind_addr;
    logic sk_l;
    logic sk;
    logic so;
    logic si_m;
    logic si_s;
    logic si_prev;
    logic so_m;
    logic so_s;
  } ifs_state_t;
endpackage

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import ifs_pkg::*;
;
  logic clk_sys;
  logic nrst;
  logic [1:0] osc_sel;
  logic rom_wr_en;
  logic [8:0] rom_wr_addr;
  logic [7:0] rom_wr_data;
  logic si_pin;
  logic so_pin_i;
  ifs_serial_out_t ser_out;
  logic [8:0] pc_out;
  logic [7:0] lookup_out;
  logic [3:0] working_out;
  logic [3:0] shift_count_out;
  logic [3:0] func_sel_out;
  logic [8:0] first_return_slot;
  logic [8:0] second_return_slot;
  logic cyc_tick_out;
  ifs_test_t test_mode;
  int miscompares;
  int total_checks;
  logic sk_seen;
  logic [8:0] pc_hold;
  // Program image as {address, byte}; only words that are executed or read as data are loaded
  logic [16:0] img [24] = '{
    17'h0_0000, 17'h0_0122, 17'h0_0255, 17'h0_034F, 17'h0_0473, 17'h0_0550,
    17'h0_0652, 17'h0_0768, 17'h0_0840, 17'h0_09FF, 17'h0_23A5, 17'h0_40BF,
    17'h0_4148, 17'h0_A522, 17'h0_A620, 17'h0_A7FF, 17'h0_A860, 17'h0_A9FF,
    17'h0_FFFF, 17'h1_233C, 17'h1_3C32, 17'h1_3D4F, 17'h1_3E44, 17'h1_3F44};

  ifs_core i_ifs_core (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .osc_sel(osc_sel),
    .rom_wr_en(rom_wr_en),
    .rom_wr_addr(rom_wr_addr),
    .rom_wr_data(rom_wr_data),
    .si_pin(si_pin),
    .so_pin_i(so_pin_i),
    .ser_out(ser_out),
    .pc_out(pc_out),
    .lookup_out(lookup_out),
    .working_out(working_out),
    .shift_count_out(shift_count_out),
    .func_sel_out(func_sel_out),
    .first_return_slot(first_return_slot),
    .second_return_slot(second_return_slot),
    .cyc_tick_out(cyc_tick_out),
    .test_mode(test_mode)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic end_sim;
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [8:0] got, input logic [8:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s is %h, expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s is %b, expected %b", $time, what, got, exp);
    end
  endtask

  // One instruction cycle; div 0 skips the spacing check after a restart
  task automatic step(input int div);
    int n;
    logic found;
    n = 0;
    found = 1'b0;
    sk_seen = 1'b0;
    for (int i = 0; i < 20 && !found; i++) begin
      @(negedge clk_sys);
      n++;
      sk_seen = sk_seen | ser_out.sk_o;
      found = (cyc_tick_out === 1'b1);
    end
    if (!found) begin
      miscompares++;
      $display("CHECK FAILED at %0t: no instruction tick", $time);
      end_sim();
    end
    @(posedge clk_sys);
    #1;
    if (div != 0) chk_val(9'(n), 9'(div), "tick spacing");
  endtask

  task automatic rst(input logic [1:0] osc);
    @(posedge clk_sys);
    nrst <= 1'b0;
    osc_sel <= osc;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
  endtask

  task automatic load_rom;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk_sys);
      rom_wr_en <= 1'b1;
      rom_wr_addr <= img[i][16:8];
      rom_wr_data <= img[i][7:0];
    end
    @(posedge clk_sys);
    rom_wr_en <= 1'b0;
  endtask

  task automatic put_rom(input logic [8:0] addr, input logic [7:0] data);
    @(posedge clk_sys);
    rom_wr_en <= 1'b1;
    rom_wr_addr <= addr;
    rom_wr_data <= data;
    @(posedge clk_sys);
    rom_wr_en <= 1'b0;
  endtask

  initial begin
    nrst = 1'b0;
    osc_sel = OSC_RC;
    rom_wr_en = 1'b0;
    rom_wr_addr = 9'h000;
    rom_wr_data = 8'h00;
    si_pin = 1'b0;
    so_pin_i = 1'b0;
    miscompares = 0;
    total_checks = 0;
    // Image goes in while reset holds, so no unloaded byte is executed
    repeat (3) @(posedge clk_sys);
    load_rom();
    rst(OSC_RC);
    step(0);
    chk_val(9'(working_out), 9'h000, "working");
    step(4);
    step(4);
    chk_val(9'(working_out), 9'h005, "working");
    step(4);
    chk_val(9'(working_out), 9'h000, "working");
    chk_val(9'(shift_count_out), 9'h005, "shift reg");
    step(4);
    chk_val(9'(shift_count_out), 9'h00A, "shift reg");
    step(4);
    chk_flag(sk_seen, 1'b1, "serial clock");
    step(4);
    step(4);
    step(4);
    chk_val(pc_out, 9'h040, "pc");
    chk_val(first_return_slot, 9'h009, "slot a");
    // Table load: push, point at working/RAM nibbles, then fetch and pop
    step(4);
    chk_val(pc_out, 9'h023, "pc");
    chk_val(first_return_slot, 9'h041, "slot a");
    chk_val(second_return_slot, 9'h009, "slot b");
    step(4);
    chk_val(9'(lookup_out), 9'h0A5, "lookup");
    chk_val(pc_out, 9'h041, "pc");
    chk_val(first_return_slot, 9'h009, "slot a");
    chk_val(second_return_slot, 9'h009, "slot b");
    step(4);
    chk_val(pc_out, 9'h009, "pc");
    step(4);
    chk_val(pc_out, 9'h00A, "pc");
    step(4);
    chk_val(pc_out, 9'h0A5, "pc");
    // Skipped indirect jump costs a single cycle
    step(4);
    step(4);
    step(4);
    chk_val(pc_out, 9'h0A8, "pc");
    chk_val(9'(working_out), 9'h002, "working");
    step(4);
    step(4);
    chk_val(pc_out, 9'h0FF, "pc");
    // Indirect jump in the last word of page 3 reads the upper group
    step(4);
    chk_val(pc_out, 9'h100, "pc");
    step(4);
    chk_val(pc_out, 9'h13C, "pc");
    step(4);
    step(4);
    chk_val(9'(working_out), 9'h000, "working");
    chk_val(9'(shift_count_out), 9'h002, "shift reg");
    step(4);
    step(4);
    chk_flag(sk_seen, 1'b0, "serial clock");
    chk_val(pc_out, 9'h140, "pc");
    rst(OSC_XTAL);
    step(0);
    step(8);
    step(8);
    chk_val(pc_out, 9'h003, "pc");
    // Pin held high across reset so entry lands before the second tick
    @(posedge clk_sys);
    so_pin_i <= 1'b1;
    rst(OSC_SCHMITT);
    repeat (20) @(posedge clk_sys);
    #1;
    chk_flag(test_mode.rom, 1'b1, "rom test");
    chk_flag(test_mode.ram_logic, 1'b0, "ram test");
    chk_val(pc_out, 9'h001, "pc");
    @(posedge clk_sys);
    si_pin <= 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
    chk_flag(test_mode.ram_logic, 1'b1, "ram test");
    chk_flag(test_mode.rom, 1'b0, "rom test");
    @(posedge clk_sys);
    so_pin_i <= 1'b0;
    si_pin <= 1'b0;
    step(0);
    step(4);
    // Counter mode: function select 9 counts si falls and drives so from its top bit
    @(posedge clk_sys);
    nrst <= 1'b0;
    put_rom(9'h001, 8'h33);
    put_rom(9'h002, 8'h69);
    put_rom(9'h003, 8'h44);
    put_rom(9'h004, 8'h44);
    put_rom(9'h005, 8'h44);
    put_rom(9'h006, 8'h4F);
    rst(OSC_RC);
    step(0);
    step(4);
    step(4);
    chk_val(9'(func_sel_out), 9'h009, "function select");
    repeat (3) begin
      @(posedge clk_sys);
      si_pin <= 1'b1;
      @(posedge clk_sys);
      si_pin <= 1'b0;
    end
    step(0);
    step(4);
    step(4);
    chk_val(pc_out, 9'h007, "pc");
    chk_val(9'(working_out), 9'h003, "counted falls");
    chk_flag(ser_out.so_o, 1'b1, "serial out");
    chk_flag(ser_out.so_oe_n, 1'b0, "serial out enable");
    chk_flag(ser_out.sk_o, 1'b0, "serial clock");
    end_sim();
  end
endmodule
